//--- rtl/uadc_attach_ctrl.sv
// usb attach/detach control: pull-up, vbus sense, detach and wake lines
// assumes synchronous strobes on clk_sys and io inputs that may be asynchronous
// offsets, field positions and the reset values of the settings and suspend enable are macros of the shared params header
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "uadc_params.svh"

module uadc_attach_ctrl (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   // register port
   input wire uadc_pkg::uadc_addr_type reg_addr,
   input wire uadc_pkg::uadc_data_type reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // general io lines
   input wire uadc_pkg::uadc_io_type io_in,
   output uadc_pkg::uadc_io_type io_out,
   output uadc_pkg::uadc_io_type io_oe,
   // usb side
   input wire logic bus_suspend,
   input wire logic enum_done,
   output logic internal_pullup_on,
   output logic data_lines_float,
   output logic remote_wake_req,
   output logic radio_enable,
   output logic aux_power_enable,
   output logic [8:0] current_request_ma,
   output logic peripheral_only,
   output logic irq
);
   import uadc_pkg::*;

   logic ctrl_ready;
   logic ctrl_selfpwr;
   logic ctrl_wake;
   logic ctrl_suspend_en;
   logic ctrl_remote_wake;
   logic [`UADC_SET_W-1:0] pullup_source_setting;
   logic [`UADC_IO_W-1:0] vbus_sense_pin_setting;
   logic [`UADC_IO_W-1:0] detach_pin_setting;
   logic [`UADC_IO_W-1:0] wake_pin_setting;
   logic [`UADC_IRQ_W-1:0] irq_status;
   logic [`UADC_IRQ_W-1:0] irq_mask;
   logic [`UADC_IRQ_W-1:0] irq_event;
   uadc_io_type io_meta;
   uadc_io_type io_sync;
   logic detach_level;
   logic detach_prev;
   logic vbus_level;
   logic vbus_prev;
   logic vbus_ok;
   logic pullup_want;
   logic ext_pullup;
   logic [`UADC_IO_W-1:0] ext_line;
   logic in_suspend;
   logic bus_powered;
   uadc_state_type state;
   uadc_state_type next_state;

   // helpers
   function automatic logic pick_line(input uadc_io_type lines, input logic [`UADC_IO_W-1:0] sel);
      pick_line = lines[sel];
   endfunction : pick_line

   function automatic logic vbus_line_ok(input logic [`UADC_IO_W-1:0] sel);
      vbus_line_ok = (sel >= `UADC_VBUS_LO) && (sel <= `UADC_VBUS_HI);
   endfunction : vbus_line_ok

   function automatic logic rose_now(input logic prev, input logic cur);
      rose_now = !prev && cur;
   endfunction : rose_now

   function automatic logic fell_now(input logic prev, input logic cur);
      fell_now = prev && !cur;
   endfunction : fell_now

   function automatic logic write_hit(input logic strobe, input uadc_addr_type addr, input uadc_addr_type target);
      write_hit = strobe && (addr == target);
   endfunction : write_hit

   // two-stage synchroniser on io inputs
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         io_meta <= '0;
         io_sync <= '0;
      end else if (clk_en) begin
         io_meta <= io_in;
         io_sync <= io_meta;
      end
   end

   assign detach_level = pick_line(io_sync, detach_pin_setting);
   // vbus only valid on lines 2..7
   assign vbus_level = vbus_line_ok(vbus_sense_pin_setting)
      && pick_line(io_sync, vbus_sense_pin_setting);
   assign bus_powered = !ctrl_selfpwr;
   assign vbus_ok = bus_powered || vbus_level;
   assign ext_pullup = (pullup_source_setting != `UADC_PULLUP_INTERNAL);
   assign ext_line = pullup_source_setting[`UADC_IO_W-1:0];
   assign pullup_want = ctrl_ready && vbus_ok && !detach_level;
   assign in_suspend = (state == UADC_SUSPENDED);

   // previous detach level for edge events
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         detach_prev <= 1'b0;
      end else if (clk_en) begin
         detach_prev <= detach_level;
      end
   end

   // previous vbus level for edge events
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         vbus_prev <= 1'b0;
      end else if (clk_en) begin
         vbus_prev <= vbus_level;
      end
   end

   // edge events for sticky status
   assign irq_event[`UADC_IRQ_ATTACH] = fell_now(detach_prev, detach_level);
   assign irq_event[`UADC_IRQ_DETACH] = rose_now(detach_prev, detach_level);
   assign irq_event[`UADC_IRQ_VBUS_ON] = rose_now(vbus_prev, vbus_level);
   assign irq_event[`UADC_IRQ_VBUS_OFF] = fell_now(vbus_prev, vbus_level);

   // connection state
   always_comb begin
      next_state = state;
      case (state)
         UADC_DETACHED: begin
            if (pullup_want) begin
               next_state = UADC_WAIT_ENUM;
            end
         end
         UADC_WAIT_ENUM: begin
            if (!pullup_want) begin
               next_state = UADC_DETACHED;
            end else if (enum_done) begin
               next_state = UADC_ATTACHED;
            end
         end
         UADC_ATTACHED: begin
            if (!pullup_want) begin
               next_state = UADC_DETACHED;
            end else if (bus_suspend && ctrl_suspend_en) begin
               next_state = UADC_SUSPENDED;
            end
         end
         UADC_SUSPENDED: begin
            if (!pullup_want) begin
               next_state = UADC_DETACHED;
            end else if (!bus_suspend) begin
               next_state = UADC_ATTACHED;
            end
         end
         default: begin
            next_state = UADC_DETACHED;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= UADC_DETACHED;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // control register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_ready <= 1'b0;
         ctrl_selfpwr <= 1'b0;
         ctrl_wake <= 1'b0;
         ctrl_suspend_en <= `UADC_SUSPEND_EN_RESET;
         ctrl_remote_wake <= 1'b0;
      end else if (clk_en && write_hit(reg_write, reg_addr, `UADC_REG_CTRL)) begin
         ctrl_ready <= reg_wdata[`UADC_CTRL_READY];
         ctrl_selfpwr <= reg_wdata[`UADC_CTRL_SELFPWR];
         ctrl_wake <= reg_wdata[`UADC_CTRL_WAKE];
         ctrl_suspend_en <= reg_wdata[`UADC_CTRL_SUSPEND];
         ctrl_remote_wake <= reg_wdata[`UADC_CTRL_REMOTE_WAKE];
      end
   end

   // pull-up source setting
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pullup_source_setting <= `UADC_PULLUP_INTERNAL;
      end else if (clk_en && write_hit(reg_write, reg_addr, `UADC_REG_PULLUP)) begin
         pullup_source_setting <= reg_wdata[`UADC_SET_W-1:0];
      end
   end

   // vbus sense line setting
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         vbus_sense_pin_setting <= `UADC_VBUS_LO;
      end else if (clk_en && write_hit(reg_write, reg_addr, `UADC_REG_VBUS)) begin
         vbus_sense_pin_setting <= reg_wdata[`UADC_IO_W-1:0];
      end
   end

   // detach line setting
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         detach_pin_setting <= `UADC_DETACH_PIN_RESET;
      end else if (clk_en && write_hit(reg_write, reg_addr, `UADC_REG_DETACH)) begin
         detach_pin_setting <= reg_wdata[`UADC_IO_W-1:0];
      end
   end

   // wake line setting
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wake_pin_setting <= `UADC_WAKE_PIN_RESET;
      end else if (clk_en && write_hit(reg_write, reg_addr, `UADC_REG_WAKE)) begin
         wake_pin_setting <= reg_wdata[`UADC_IO_W-1:0];
      end
   end

   // interrupt mask
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_mask <= '0;
      end else if (clk_en && write_hit(reg_write, reg_addr, `UADC_REG_MASK)) begin
         irq_mask <= reg_wdata[`UADC_IRQ_W-1:0];
      end
   end

   // sticky status, set wins over write-one-clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_status <= '0;
      end else if (clk_en) begin
         if (reg_write && reg_addr == `UADC_REG_IRQ) begin
            irq_status <= (irq_status & ~reg_wdata[`UADC_IRQ_W-1:0]) | irq_event;
         end else begin
            irq_status <= irq_status | irq_event;
         end
      end
   end

   // read data, one cycle later
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0;
      end else if (clk_en) begin
         reg_rdata <= 32'h0;
         if (reg_read) begin
            case (reg_addr)
               `UADC_REG_CTRL: reg_rdata <= {27'h0, ctrl_remote_wake, ctrl_suspend_en, ctrl_wake,
                  ctrl_selfpwr, ctrl_ready};
               `UADC_REG_PULLUP: reg_rdata <= {27'h0, pullup_source_setting};
               `UADC_REG_VBUS: reg_rdata <= {29'h0, vbus_sense_pin_setting};
               `UADC_REG_DETACH: reg_rdata <= {29'h0, detach_pin_setting};
               `UADC_REG_WAKE: reg_rdata <= {29'h0, wake_pin_setting};
               `UADC_REG_STATUS: reg_rdata <= {24'h0, state, 1'b0, vbus_level, detach_level, pullup_want};
               `UADC_REG_IRQ: reg_rdata <= {28'h0, irq_status};
               `UADC_REG_MASK: reg_rdata <= {28'h0, irq_mask};
               `UADC_REG_CURRENT: reg_rdata <= {23'h0, `UADC_CURRENT_MA};
               default: reg_rdata <= 32'h0;
            endcase
         end
      end
   end

   // d+ pull-up and data line state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         internal_pullup_on <= 1'b0;
         data_lines_float <= 1'b1;
      end else if (clk_en) begin
         internal_pullup_on <= pullup_want && !ext_pullup;
         data_lines_float <= detach_level;
      end
   end

   // io drivers: external pull-up line and wake line
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         io_out <= '0;
         io_oe <= '0;
      end else if (clk_en) begin
         io_out <= '0;
         io_oe <= '0;
         if (ext_pullup && pullup_want) begin
            io_out[ext_line] <= 1'b1;
            io_oe[ext_line] <= 1'b1;
         end
         if (detach_level) begin
            io_out[wake_pin_setting] <= ctrl_wake;
            io_oe[wake_pin_setting] <= 1'b1;
         end
      end
   end

   // in-band remote wakeup request
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         remote_wake_req <= 1'b0;
      end else if (clk_en) begin
         remote_wake_req <= ctrl_remote_wake && !detach_level && in_suspend;
      end
   end

   // radio off while suspended on bus power
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         radio_enable <= 1'b0;
      end else if (clk_en) begin
         radio_enable <= !(in_suspend && bus_powered);
      end
   end

   // leds and amplifiers off in suspend
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         aux_power_enable <= 1'b0;
      end else if (clk_en) begin
         aux_power_enable <= !in_suspend;
      end
   end

   // current asked for at enumeration
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         current_request_ma <= 9'h0;
      end else if (clk_en) begin
         current_request_ma <= bus_powered ? `UADC_CURRENT_MA : 9'h0;
      end
   end

   // peripheral role only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         peripheral_only <= 1'b1;
      end else if (clk_en) begin
         peripheral_only <= 1'b1;
      end
   end

   // level interrupt
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |((irq_status | irq_event) & irq_mask);
      end
   end
endmodule : uadc_attach_ctrl

//--- shared/uadc_params.svh
// constants of the usb attach/detach control block
// assumes inclusion by the package, the design module and the bench
`ifndef UADC_PARAMS_SVH
`define UADC_PARAMS_SVH
`define UADC_NUM_IO 8
`define UADC_IO_W 3
`define UADC_SET_W 5
`define UADC_PULLUP_INTERNAL 5'h10
`define UADC_SUSPEND_EN_RESET 1'b1
`define UADC_DETACH_PIN_RESET 3'h0
`define UADC_WAKE_PIN_RESET 3'h1
`define UADC_VBUS_LO 3'h2
`define UADC_VBUS_HI 3'h7
`define UADC_CURRENT_MA 9'h064
`define UADC_ADDR_W 4
`define UADC_REG_CTRL 4'h0
`define UADC_REG_PULLUP 4'h1
`define UADC_REG_VBUS 4'h2
`define UADC_REG_DETACH 4'h3
`define UADC_REG_WAKE 4'h4
`define UADC_REG_STATUS 4'h5
`define UADC_REG_IRQ 4'h6
`define UADC_REG_MASK 4'h7
`define UADC_REG_CURRENT 4'h8
`define UADC_CTRL_READY 0
`define UADC_CTRL_SELFPWR 1
`define UADC_CTRL_WAKE 2
`define UADC_CTRL_SUSPEND 3
`define UADC_CTRL_REMOTE_WAKE 4
`define UADC_IRQ_ATTACH 0
`define UADC_IRQ_DETACH 1
`define UADC_IRQ_VBUS_ON 2
`define UADC_IRQ_VBUS_OFF 3
`define UADC_IRQ_W 4
`endif

//--- shared/uadc_pkg.sv
// types of the usb attach/detach control block
// assumes uadc_params.svh on the include path
`include "uadc_params.svh"
package uadc_pkg;
   typedef logic [`UADC_ADDR_W-1:0] uadc_addr_type;
   typedef logic [31:0] uadc_data_type;
   typedef logic [`UADC_NUM_IO-1:0] uadc_io_type;
   typedef enum logic [3:0] {
      UADC_DETACHED = 4'h1,
      UADC_WAIT_ENUM = 4'h2,
      UADC_ATTACHED = 4'h4,
      UADC_SUSPENDED = 4'h8
   } uadc_state_type;
endpackage : uadc_pkg

//--- testbench/testbench.sv
// self-checking bench of the attach/detach port with a host model
// assumes reset mapping detach io 0, wake io 1, vbus io 2
`timescale 1ns/1ps
`include "uadc_params.svh"
module testbench;
   import uadc_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic suspend_cmd = 1'b0;
   logic clk_en = 1'b1;
   uadc_addr_type reg_addr = 4'h0;
   uadc_data_type reg_wdata = 32'h0;
   uadc_io_type io_in = 8'h00;
   uadc_io_type io_out, io_oe;
   logic [31:0] reg_rdata;
   logic [8:0] current_request_ma;
   logic internal_pullup_on, data_lines_float, remote_wake_req, radio_enable;
   logic aux_power_enable, peripheral_only, irq, bus_suspend, enum_done, pullup_seen;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   uadc_addr_type ra[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hf};
   logic [31:0] rv[7] = '{32'h8, 32'h10, 32'h2, 32'h0, 32'h1, 32'h64, 32'h0};
   assign pullup_seen = internal_pullup_on | (io_oe[3] & io_out[3]);
   always #5 clk_sys = ~clk_sys;
   uadc_attach_ctrl uadc_attach_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe), .bus_suspend(bus_suspend), .enum_done(enum_done),
      .internal_pullup_on(internal_pullup_on), .data_lines_float(data_lines_float),
      .remote_wake_req(remote_wake_req), .radio_enable(radio_enable), .aux_power_enable(aux_power_enable),
      .current_request_ma(current_request_ma), .peripheral_only(peripheral_only), .irq(irq));
   uadc_host_model uadc_host_model_inst (.clk_sys(clk_sys), .rst(rst), .pullup_seen(pullup_seen),
      .suspend_cmd(suspend_cmd), .bus_suspend(bus_suspend), .enum_done(enum_done));
   task complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task wr(input uadc_addr_type a, input uadc_data_type d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask : wr
   task rd(input uadc_addr_type a, input logic [31:0] ex);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 chk("reg_rdata", ex, reg_rdata);
   endtask : rd
   task io(input int b, input logic v);
      @(posedge clk_sys);
      io_in[b] <= v;
   endtask : io
   task settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : settle
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         complete_run();
      end
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
      chk("pullup", 1'b0, internal_pullup_on);
      wr(`UADC_REG_CTRL, 32'h9);
      settle(3);
      chk("pullup", 1'b1, internal_pullup_on);
      chk("current", 9'h064, current_request_ma);
      chk("role", 1'b1, peripheral_only);
      wr(`UADC_REG_MASK, 32'h3);
      rd(`UADC_REG_STATUS, 32'h41);
      rd(`UADC_REG_MASK, 32'h3);
      wr(`UADC_REG_CTRL, 32'hd);
      io(0, 1'b1);
      settle(1);
      chk("float", 1'b0, data_lines_float);
      settle(3);
      chk("float", 1'b1, data_lines_float);
      chk("pullup", 1'b0, internal_pullup_on);
      chk("wake", 2'h3, {io_oe[1], io_out[1]});
      chk("irq", 1'b1, irq);
      rd(`UADC_REG_IRQ, 32'h2);
      wr(`UADC_REG_IRQ, 32'h2);
      settle(2);
      chk("irq", 1'b0, irq);
      io(0, 1'b0);
      settle(4);
      chk("float", 1'b0, data_lines_float);
      chk("pullup", 1'b1, internal_pullup_on);
      chk("wake_oe", 1'b0, io_oe[1]);
      rd(`UADC_REG_IRQ, 32'h1);
      wr(`UADC_REG_CTRL, 32'h19);
      @(posedge clk_sys) suspend_cmd <= 1'b1;
      settle(10);
      chk("radio_aux", 2'h0, {radio_enable, aux_power_enable});
      chk("rwake", 1'b1, remote_wake_req);
      io(0, 1'b1);
      settle(4);
      chk("rwake", 1'b0, remote_wake_req);
      io(0, 1'b0);
      @(posedge clk_sys) suspend_cmd <= 1'b0;
      wr(`UADC_REG_PULLUP, 32'h3);
      wr(`UADC_REG_CTRL, 32'hf);
      settle(4);
      chk("ext_pullup", 1'b0, io_out[3] & io_oe[3]);
      chk("current", 9'h000, current_request_ma);
      io(2, 1'b1);
      settle(4);
      chk("ext_pullup", 1'b1, io_out[3] & io_oe[3]);
      chk("int_pullup", 1'b0, internal_pullup_on);
      wr(`UADC_REG_VBUS, 32'h1);
      io(1, 1'b1);
      settle(4);
      chk("ext_pullup", 1'b0, io_out[3] & io_oe[3]);
      wr(`UADC_REG_VBUS, 32'h2);
      wr(`UADC_REG_DETACH, 32'h5);
      wr(`UADC_REG_WAKE, 32'h6);
      io(5, 1'b1);
      settle(4);
      chk("float", 1'b1, data_lines_float);
      chk("wake_oe", 1'b1, io_oe[6]);
      @(posedge clk_sys) clk_en <= 1'b0;
      wr(`UADC_REG_WAKE, 32'h2);
      @(posedge clk_sys) clk_en <= 1'b1;
      rd(`UADC_REG_WAKE, 32'h6);
      complete_run();
   end
endmodule : testbench
bind uadc_attach_ctrl uadc_attach_monitor uadc_attach_monitor_inst (.clk_sys(clk_sys), .rst(rst),
   .io_in(io_in), .io_oe(io_oe), .bus_suspend(bus_suspend), .internal_pullup_on(internal_pullup_on),
   .data_lines_float(data_lines_float), .remote_wake_req(remote_wake_req), .radio_enable(radio_enable),
   .current_request_ma(current_request_ma), .peripheral_only(peripheral_only));

//--- testbench/uadc_attach_monitor.sv
// checker of the attach/detach port pins
// assumes reset line mapping: detach on io 0, wake on io 1
`timescale 1ns/1ps
module uadc_attach_monitor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // watched pins
   input wire uadc_pkg::uadc_io_type io_in,
   input wire uadc_pkg::uadc_io_type io_oe,
   input wire logic bus_suspend,
   input wire logic internal_pullup_on,
   input wire logic data_lines_float,
   input wire logic remote_wake_req,
   input wire logic radio_enable,
   input wire logic [8:0] current_request_ma,
   input wire logic peripheral_only
);
   import uadc_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_float_no_pullup:
      assert property (data_lines_float |-> !internal_pullup_on) else $error("pull-up on while floating");
   a_detach_floats:
      assert property (io_in[0] [*4] |-> data_lines_float) else $error("detach ignored");
   a_sync_two_stage:
      assert property ($rose(io_in[0]) && !data_lines_float |=> !data_lines_float) else $error("detach unsynced");
   a_no_wake_detached:
      assert property (data_lines_float |-> !remote_wake_req) else $error("remote wake while detached");
   a_wake_with_detach:
      assert property (io_oe[1] |-> data_lines_float || $past(data_lines_float)) else $error("wake without detach");
   a_radio_off_susp:
      assert property ((bus_suspend && internal_pullup_on) [*6] |-> !radio_enable) else $error("radio on in suspend");
   a_current_bus_pwr:
      assert property (internal_pullup_on |-> current_request_ma == 9'h064) else $error("wrong current");
   a_peripheral_role:
      assert property (peripheral_only) else $error("host role taken");
endmodule : uadc_attach_monitor

//--- testbench/uadc_host_model.sv
// host controller model: enumerates an attached port, suspends it on request
// assumes the bench commands suspend
`timescale 1ns/1ps
module uadc_host_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // port side
   input wire logic pullup_seen,
   input wire logic suspend_cmd,
   output logic bus_suspend,
   output logic enum_done
);
   logic [1:0] seen;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         seen <= 2'h0;
         enum_done <= 1'b0;
         bus_suspend <= 1'b0;
      end else begin
         seen <= {seen[0], pullup_seen};
         enum_done <= seen[0] && !seen[1];
         bus_suspend <= suspend_cmd && seen[1];
      end
   end
endmodule : uadc_host_model
